//--- core/hbg_pkg.sv
`default_nettype none

package hbg_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ = 10_000_000;
  localparam int unsigned SLEEP_HOLD_US = 30;
  localparam int unsigned SLEEP_HOLD_CYC_I =
    (SLEEP_HOLD_US * CLK_FREQ_HZ + 999_999) / 1_000_000;
  localparam logic [9:0] SLEEP_HOLD_CYC = 10'(SLEEP_HOLD_CYC_I);
  localparam int unsigned ENA_TIMEOUT_US = 50;
  localparam int unsigned ENA_TIMEOUT_CYC_I =
    (ENA_TIMEOUT_US * CLK_FREQ_HZ + 999_999) / 1_000_000;
  localparam logic [9:0] ENA_TIMEOUT_CYC = 10'(ENA_TIMEOUT_CYC_I);

  // ----------------------------------------------------------------
  // Serial frame layout
  // ----------------------------------------------------------------
  localparam int unsigned FRAME_BITS = 16;
  localparam logic [4:0] RX_LAST_EDGE = 5'h0f;
  localparam logic [4:0] RX_OVER_EDGE = 5'h10;
  localparam int unsigned ADDR_MSB = 15;
  localparam int unsigned ADDR_LSB = 12;
  localparam int unsigned SET_W = 6;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_DEAD = 4'h1;
  localparam logic [3:0] ADDR_BLANK = 4'h2;
  localparam logic [3:0] ADDR_VDS = 4'h3;
  localparam logic [3:0] ADDR_OPEN = 4'h4;

  // Control register bits
  localparam int unsigned CTRL_AH_BIT = 3;
  localparam int unsigned CTRL_AL_BIT = 2;
  localparam int unsigned CTRL_BH_BIT = 1;
  localparam int unsigned CTRL_BL_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [SET_W-1:0] DEAD_RST = 6'h08;
  localparam logic [SET_W-1:0] BLANK_RST = 6'h10;
  localparam logic [SET_W-1:0] VDS_RST = 6'h0c;
  localparam logic [SET_W-1:0] OPEN_RST = 6'h00;

  // ----------------------------------------------------------------
  // Synchroniser lanes
  // ----------------------------------------------------------------
  localparam int unsigned SYNC_W = 11;
  localparam int unsigned SY_STROBE = 0;
  localparam int unsigned SY_CLEAR = 1;
  localparam int unsigned SY_ENABLE = 2;
  localparam int unsigned SY_MON = 3;
  localparam int unsigned SY_FAULT = 4;
  localparam int unsigned SY_A_HI = 5;
  localparam int unsigned SY_A_LO_N = 6;
  localparam int unsigned SY_B_HI_N = 7;
  localparam int unsigned SY_B_LO = 8;
  localparam int unsigned SY_RX_VALID = 9;
  localparam int unsigned SY_RX_TGL = 10;
  localparam logic [SYNC_W-1:0] SYNC_RST = 11'h0c3;

  // Per-phase driver state
  typedef enum logic [2:0] {
    DRV_OFF = 3'b001,
    DRV_HIGH = 3'b010,
    DRV_LOW = 3'b100
  } hbg_drv_t;

endpackage

`default_nettype wire

//--- core/hbg_serial_rx.sv
`default_nettype none

module hbg_serial_rx
  import hbg_pkg::*;
(
  input wire logic i_sck, // Serial clock, link domain
  input wire logic i_rst_n, // Synchronised reset
  input wire logic i_serial_strobe_n, // Frame strobe
  input wire logic i_sdi, // Serial data in
  output logic [FRAME_BITS-1:0] o_word, // Last complete word
  output logic o_word_valid, // Exactly 16 edges seen
  output logic o_frame_tgl // Flips on first edge of a frame
);

  typedef struct packed {
    logic [FRAME_BITS-1:0] shift;
    logic [FRAME_BITS-1:0] word;
    logic valid;
    logic tgl;
  } hbg_rx_t;

  hbg_rx_t r, r_nxt;
  logic [4:0] cnt_r, cnt_nxt;

  // ----------------------------------------------------------------
  // Shift and frame tracking
  // ----------------------------------------------------------------
  always_comb begin
    r_nxt = r;
    cnt_nxt = cnt_r;
    if (!i_serial_strobe_n) begin
      r_nxt.shift = {r.shift[FRAME_BITS-2:0], i_sdi};
      if (cnt_r == 5'h00) begin
        r_nxt.tgl = ~r.tgl;
        r_nxt.valid = 1'b0;
      end
      if (cnt_r == RX_LAST_EDGE) begin
        r_nxt.word = {r.shift[FRAME_BITS-2:0], i_sdi};
        r_nxt.valid = 1'b1;
      end
      if (cnt_r == RX_OVER_EDGE) begin
        r_nxt.valid = 1'b0;
      end
      if (cnt_r != RX_OVER_EDGE) begin
        cnt_nxt = cnt_r + 5'h01;
      end
    end
  end

  always_ff @(posedge i_sck or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  // Edge count restarts whenever the strobe is high
  always_ff @(posedge i_sck or negedge i_rst_n or posedge i_serial_strobe_n) begin
    if (!i_rst_n) begin
      cnt_r <= 5'h00;
    end else if (i_serial_strobe_n) begin
      cnt_r <= 5'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign o_word = r.word;
  assign o_word_valid = r.valid;
  assign o_frame_tgl = r.tgl;

endmodule // hbg_serial_rx

`default_nettype wire

//--- core/hbg_gate_ctrl.sv
`default_nettype none

// Summary of operation
// - Phase A: high in 1 and low_n 1 drives high; both 0 drives low.
// - Phase B: both 0 drives high, both 1 drives low, mixed is off.
// - Register pair decodes 00 off, 01 low, 10 high, 11 off.
// - Pin and register requests OR per side; both sides requested means off.
// - High and low driver of one phase never on together.
// - Switching sides inserts programmable dead time with both drivers off.
// - One PWM on both inputs of a phase alternates high and low.
// - Dead time, blanking, short and open-load settings written serially.
// - Each frame is sixteen bits, most significant first.
// - Data sampled on rising serial clock while strobe is low.
// - Strobe high ignores clock and data and floats serial output.
// - Strobe low drives serial output with the global fault flag.
// - Short low pulse on clear pin clears latched faults.
// - Clear pin held low enters sleep with all gates off.
// - Enable low kills gates, at once or after timeout in monitor mode.

module hbg_gate_ctrl
  import hbg_pkg::*;
(
  input wire logic i_clock, // System clock
  input wire logic i_rst_n, // Async reset, active low
  input wire logic i_sck, // Serial clock
  input wire logic i_serial_strobe_n, // Serial strobe, active low
  input wire logic i_sdi, // Serial data in
  input wire logic i_phase_a_high_request_in, // Phase A high, active high
  input wire logic i_phase_a_low_request_in_n, // Phase A low, active low
  input wire logic i_phase_b_high_request_in_n, // Phase B high, active low
  input wire logic i_phase_b_low_request_in, // Phase B low, active high
  input wire logic i_fault_clear_sleep_n, // Fault clear and sleep pin
  input wire logic i_enable, // Gate enable pin
  input wire logic i_monitor_mode, // Enable timeout mode select
  input wire logic i_fault_event, // Raw fault indication
  output logic o_phase_a_upper_gate_out, // Phase A high-side gate
  output logic o_phase_a_lower_gate_out, // Phase A low-side gate
  output logic o_phase_b_upper_gate_out, // Phase B high-side gate
  output logic o_phase_b_lower_gate_out, // Phase B low-side gate
  output logic o_sdo, // Serial data out
  output logic o_sdo_oe, // Serial data out enable
  output logic o_sleep, // Sleep state
  output logic o_fault_flag, // Latched global fault
  output logic [SET_W-1:0] o_dead_time, // Dead time setting
  output logic [SET_W-1:0] o_blank_time, // Fault blank setting
  output logic [SET_W-1:0] o_vds_threshold, // Short-detect threshold
  output logic [SET_W-1:0] o_open_load_cfg // Open-load setting
);

  typedef struct packed {
    logic [SYNC_W-1:0] meta;
    logic [SYNC_W-1:0] sync;
    logic strobe_d;
    logic seen_tgl;
    logic [3:0] ctrl;
    logic [SET_W-1:0] dead;
    logic [SET_W-1:0] blank;
    logic [SET_W-1:0] vds;
    logic [SET_W-1:0] open_load;
    hbg_drv_t [1:0] state;
    logic [1:0][SET_W-1:0] dcnt;
    logic [9:0] clr_cnt;
    logic sleep;
    logic fault;
    logic [9:0] ena_cnt;
    logic kill;
    logic [3:0] gate;
    logic sdo;
    logic sdo_oe;
  } hbg_sys_t;

  localparam hbg_sys_t S_RST = '{
    meta: SYNC_RST, sync: SYNC_RST, strobe_d: 1'b1, seen_tgl: 1'b0,
    ctrl: CTRL_RST, dead: DEAD_RST, blank: BLANK_RST, vds: VDS_RST,
    open_load: OPEN_RST, state: '{DRV_OFF, DRV_OFF}, dcnt: '0,
    clr_cnt: 10'h000, sleep: 1'b0, fault: 1'b0, ena_cnt: 10'h000,
    kill: 1'b1, gate: 4'h0, sdo: 1'b0, sdo_oe: 1'b0
  };

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_r;
  logic rst_n;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_r[1];

  // ----------------------------------------------------------------
  // Serial receiver, link domain
  // ----------------------------------------------------------------
  logic [FRAME_BITS-1:0] rx_word;
  logic rx_valid;
  logic rx_tgl;

  hbg_serial_rx u_rx (
    .i_sck(i_sck),
    .i_rst_n(rst_n),
    .i_serial_strobe_n(i_serial_strobe_n),
    .i_sdi(i_sdi),
    .o_word(rx_word),
    .o_word_valid(rx_valid),
    .o_frame_tgl(rx_tgl)
  );

  // ----------------------------------------------------------------
  // Control core
  // ----------------------------------------------------------------
  hbg_sys_t s, s_nxt;
  logic str_s, clr_s, en_s, mon_s, fault_s;
  logic frame_end;
  logic clear_faults;
  logic block;
  logic [1:0] pin_hi, pin_lo, reg_hi, reg_lo, hi_req, lo_req;
  hbg_drv_t [1:0] want;

  assign str_s = s.sync[SY_STROBE];
  assign clr_s = s.sync[SY_CLEAR];
  assign en_s = s.sync[SY_ENABLE];
  assign mon_s = s.sync[SY_MON];
  assign fault_s = s.sync[SY_FAULT];
  assign frame_end = str_s & ~s.strobe_d;

  // Direct inputs normalised to active high
  assign pin_hi[0] = s.sync[SY_A_HI];
  assign pin_lo[0] = ~s.sync[SY_A_LO_N];
  assign pin_hi[1] = ~s.sync[SY_B_HI_N];
  assign pin_lo[1] = s.sync[SY_B_LO];
  assign reg_hi = {s.ctrl[CTRL_BH_BIT], s.ctrl[CTRL_AH_BIT]};
  assign reg_lo = {s.ctrl[CTRL_BL_BIT], s.ctrl[CTRL_AL_BIT]};
  assign hi_req = pin_hi | reg_hi;
  assign lo_req = pin_lo | reg_lo;

  always_comb begin
    s_nxt = s;
    s_nxt.meta[SY_STROBE] = i_serial_strobe_n;
    s_nxt.meta[SY_CLEAR] = i_fault_clear_sleep_n;
    s_nxt.meta[SY_ENABLE] = i_enable;
    s_nxt.meta[SY_MON] = i_monitor_mode;
    s_nxt.meta[SY_FAULT] = i_fault_event;
    s_nxt.meta[SY_A_HI] = i_phase_a_high_request_in;
    s_nxt.meta[SY_A_LO_N] = i_phase_a_low_request_in_n;
    s_nxt.meta[SY_B_HI_N] = i_phase_b_high_request_in_n;
    s_nxt.meta[SY_B_LO] = i_phase_b_low_request_in;
    s_nxt.meta[SY_RX_VALID] = rx_valid;
    s_nxt.meta[SY_RX_TGL] = rx_tgl;
    s_nxt.sync = s.meta;

    // Word is stable while the strobe is high, so it is read here
    s_nxt.strobe_d = str_s;
    if (frame_end) begin
      s_nxt.seen_tgl = s.sync[SY_RX_TGL];
      if (s.sync[SY_RX_VALID] && (s.sync[SY_RX_TGL] != s.seen_tgl)) begin
        unique case (rx_word[ADDR_MSB:ADDR_LSB])
          ADDR_CTRL: s_nxt.ctrl = rx_word[3:0];
          ADDR_DEAD: s_nxt.dead = rx_word[SET_W-1:0];
          ADDR_BLANK: s_nxt.blank = rx_word[SET_W-1:0];
          ADDR_VDS: s_nxt.vds = rx_word[SET_W-1:0];
          ADDR_OPEN: s_nxt.open_load = rx_word[SET_W-1:0];
          default: s_nxt.ctrl = s.ctrl;
        endcase
      end
    end

    // Clear pin: short pulse clears faults, long hold sleeps
    clear_faults = 1'b0;
    if (!clr_s) begin
      if (s.clr_cnt != SLEEP_HOLD_CYC) begin
        s_nxt.clr_cnt = s.clr_cnt + 10'h001;
      end else begin
        s_nxt.sleep = 1'b1;
      end
    end else begin
      clear_faults = (s.clr_cnt != 10'h000) && !s.sleep;
      s_nxt.clr_cnt = 10'h000;
      s_nxt.sleep = 1'b0;
    end
    s_nxt.fault = fault_s | (s.fault & ~clear_faults);

    // Enable pin kill path
    if (en_s) begin
      s_nxt.ena_cnt = 10'h000;
    end else if (s.ena_cnt != ENA_TIMEOUT_CYC) begin
      s_nxt.ena_cnt = s.ena_cnt + 10'h001;
    end
    s_nxt.kill = !en_s && (!mon_s || (s.ena_cnt == ENA_TIMEOUT_CYC));
    block = s_nxt.kill | s_nxt.sleep;

    // Per-phase drive with dead time
    for (int i = 0; i < 2; i++) begin
      if (hi_req[i] && !lo_req[i]) begin
        want[i] = DRV_HIGH;
      end else if (lo_req[i] && !hi_req[i]) begin
        want[i] = DRV_LOW;
      end else begin
        want[i] = DRV_OFF;
      end
      if (block) begin
        s_nxt.state[i] = DRV_OFF;
        s_nxt.dcnt[i] = s.dead;
      end else begin
        unique case (s.state[i])
          DRV_OFF: begin
            if (s.dcnt[i] != 6'h00) begin
              s_nxt.dcnt[i] = s.dcnt[i] - 6'h01;
            end else begin
              s_nxt.state[i] = want[i];
            end
          end
          DRV_HIGH, DRV_LOW: begin
            if (want[i] != s.state[i]) begin
              s_nxt.state[i] = DRV_OFF;
              s_nxt.dcnt[i] = s.dead;
            end
          end
          default: begin
            s_nxt.state[i] = DRV_OFF;
            s_nxt.dcnt[i] = s.dead;
          end
        endcase
      end
      s_nxt.gate[2*i+1] = (s_nxt.state[i] == DRV_HIGH) && !block;
      s_nxt.gate[2*i] = (s_nxt.state[i] == DRV_LOW) && !block;
    end

    // Serial output carries the fault flag during a frame
    s_nxt.sdo_oe = !str_s;
    s_nxt.sdo = s.fault;
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= S_RST;
    end else begin
      s <= s_nxt;
    end
  end

  assign o_phase_a_upper_gate_out = s.gate[1];
  assign o_phase_a_lower_gate_out = s.gate[0];
  assign o_phase_b_upper_gate_out = s.gate[3];
  assign o_phase_b_lower_gate_out = s.gate[2];
  assign o_sdo = s.sdo;
  assign o_sdo_oe = s.sdo_oe;
  assign o_sleep = s.sleep;
  assign o_fault_flag = s.fault;
  assign o_dead_time = s.dead;
  assign o_blank_time = s.blank;
  assign o_vds_threshold = s.vds;
  assign o_open_load_cfg = s.open_load;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!rst_n);

  a_lockout_phase: assert property (
    !(s.gate[1] && s.gate[0]) && !(s.gate[3] && s.gate[2]))
    else $error("both drivers of a phase on");

  a_dead_gap: assert property (
    (($fell(s.gate[1]) || $fell(s.gate[0])) && (s.dead != 6'h00))
      |-> (s.gate[1:0] == 2'b00) [*2])
    else $error("no dead time after phase A turn-off");

  a_high_cause: assert property (
    $rose(s.gate[1]) |-> $past(want[0] == DRV_HIGH))
    else $error("phase A high-side on without request");

  a_low_cause: assert property (
    $rose(s.gate[2]) |-> $past(want[1] == DRV_LOW))
    else $error("phase B low-side on without request");

  a_reg_decode: assert property (
    (s.ctrl[CTRL_AH_BIT] && !s.ctrl[CTRL_AL_BIT]
      && s.sync[SY_A_HI] == 1'b0 && s.sync[SY_A_LO_N] == 1'b1)
      |-> want[0] == DRV_HIGH)
    else $error("register high request not decoded");

  a_enable_kill: assert property (
    (!en_s && !mon_s) |=> (s.gate == 4'h0))
    else $error("gates on with enable low in direct mode");

  a_sleep_off: assert property (
    s.sleep |-> (s.gate == 4'h0))
    else $error("gates on during sleep");

  a_sdo_float: assert property (
    str_s |=> !s.sdo_oe)
    else $error("serial output driven with strobe high");

  a_sdo_fault: assert property (
    s.sdo_oe |-> (s.sdo == $past(s.fault)))
    else $error("serial output not showing fault flag");

  a_fault_clear: assert property (
    (clr_s && s.clr_cnt != 10'h000 && !s.sleep && !fault_s) |=> !s.fault)
    else $error("fault not cleared by short pulse");

  a_frame_discard: assert property (
    (frame_end && !s.sync[SY_RX_VALID]) |=> ($stable(s.ctrl) && $stable(s.dead)))
    else $error("bad frame changed a register");

  a_dead_gap_b: assert property (
    (($fell(s.gate[3]) || $fell(s.gate[2])) && (s.dead != 6'h00))
      |-> (s.gate[3:2] == 2'b00) [*2])
    else $error("no dead time after phase B turn-off");

  a_low_cause_a: assert property (
    $rose(s.gate[0]) |-> $past(want[0] == DRV_LOW))
    else $error("phase A low-side on without request");

  a_high_cause_b: assert property (
    $rose(s.gate[3]) |-> $past(want[1] == DRV_HIGH))
    else $error("phase B high-side on without request");

  a_both_off: assert property (
    (hi_req[0] && lo_req[0]) |=> (s.gate[1:0] == 2'b00))
    else $error("phase A driven with both sides requested");

  a_sleep_entry: assert property (
    (!clr_s && s.clr_cnt == SLEEP_HOLD_CYC) |=> s.sleep)
    else $error("long clear hold did not enter sleep");

  a_dead_write: assert property (
    (frame_end && s.sync[SY_RX_VALID] && (s.sync[SY_RX_TGL] != s.seen_tgl)
      && (rx_word[ADDR_MSB:ADDR_LSB] == ADDR_DEAD))
      |=> (s.dead == $past(rx_word[SET_W-1:0])))
    else $error("dead time write not applied");

  c_drive_high: cover property ($rose(s.gate[1]));
  c_drive_low: cover property ($rose(s.gate[2]));
  c_frame_ok: cover property (frame_end && s.sync[SY_RX_VALID]);
  c_sleep: cover property ($rose(s.sleep));
  c_monitor_kill: cover property (mon_s && $rose(s.kill));

endmodule // hbg_gate_ctrl

`default_nettype wire

//--- sim/hbg_host_model.sv
`default_nettype none

module hbg_host_model (
  output logic o_sck, // Serial clock to the device
  output logic o_serial_strobe_n, // Frame strobe, active low
  output logic o_sdi // Serial data to the device
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    o_sck = 1'b0;
    o_serial_strobe_n = 1'b1;
    o_sdi = 1'b0;
  end

  // ----------------------------------------------------------------
  // Frame writer
  // ----------------------------------------------------------------
  // Clock rises before and falls after each frame while the strobe is high; idle clock and data rest low
  task automatic send(input logic [15:0] word, input int edges);
    o_sck = 1'b1;
    #200;
    o_serial_strobe_n = 1'b0;
    #400;
    for (int i = 0; i < edges; i++) begin
      o_sck = 1'b0;
      o_sdi = (i < 16) ? word[15-i] : 1'b0;
      #62.5;
      o_sck = 1'b1;
      #62.5;
    end
    #400;
    o_serial_strobe_n = 1'b1;
    #200;
    o_sck = 1'b0;
    o_sdi = 1'b0;
    #400;
  endtask
endmodule // hbg_host_model

`default_nettype wire

//--- sim/tb_top.sv
`default_nettype none

module tb_top;
  import hbg_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic [3:0] pins = 4'b0110;
  logic clr_n = 1'b1;
  logic en = 1'b1;
  logic mon = 1'b0;
  logic fault = 1'b0;
  wire logic sck, strb_n, sdi;
  logic a_up, a_lo, b_up, b_lo, sdo, sdo_oe, slp, fflag;
  logic [SET_W-1:0] dead, blank, vds, openc;
  wire logic [3:0] gates = {a_up, a_lo, b_up, b_lo};
  int err_count = 0;
  int n_checks = 0;

  always #50 i_clock = ~i_clock;

  hbg_host_model host_u (.o_sck(sck), .o_serial_strobe_n(strb_n), .o_sdi(sdi));

  hbg_gate_ctrl dut_u (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_sck(sck), .i_serial_strobe_n(strb_n),
    .i_sdi(sdi), .i_phase_a_high_request_in(pins[3]), .i_phase_a_low_request_in_n(pins[2]),
    .i_phase_b_high_request_in_n(pins[1]), .i_phase_b_low_request_in(pins[0]),
    .i_fault_clear_sleep_n(clr_n), .i_enable(en), .i_monitor_mode(mon),
    .i_fault_event(fault), .o_phase_a_upper_gate_out(a_up), .o_phase_a_lower_gate_out(a_lo),
    .o_phase_b_upper_gate_out(b_up), .o_phase_b_lower_gate_out(b_lo), .o_sdo(sdo),
    .o_sdo_oe(sdo_oe), .o_sleep(slp), .o_fault_flag(fflag), .o_dead_time(dead),
    .o_blank_time(blank), .o_vds_threshold(vds), .o_open_load_cfg(openc));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_gates(input logic [3:0] exp, input int bound);
    int k;
    tick(3);
    k = 0;
    while (k < bound && gates !== exp) begin
      tick(1);
      k++;
    end
    chk(8'(gates), 8'(exp), "gates");
    if (k >= bound && gates !== exp) summarize();
  endtask

  task automatic wr(input logic [3:0] addr, input logic [5:0] data);
    host_u.send({addr, 6'h00, data}, 16);
    tick(8);
  endtask

  // Both sides of one phase must never be on together
  always @(negedge i_clock) begin
    if ((a_up & a_lo) === 1'b1 || (b_up & b_lo) === 1'b1) begin
      err_count++;
      $display("FAIL %0t shoot-through", $time);
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_settings();
    chk(8'(dead), 8'(DEAD_RST), "dead rst");
    chk(8'(blank), 8'(BLANK_RST), "blank rst");
    chk(8'(vds), 8'(VDS_RST), "vds rst");
    chk(8'(openc), 8'(OPEN_RST), "open rst");
    wr(ADDR_DEAD, 6'h05);
    wr(ADDR_BLANK, 6'h21);
    wr(ADDR_VDS, 6'h3f);
    wr(ADDR_OPEN, 6'h2a);
    chk(8'(dead), 8'h05, "dead");
    chk(8'(blank), 8'h21, "blank");
    chk(8'(vds), 8'h3f, "vds");
    chk(8'(openc), 8'h2a, "open");
  endtask

  task automatic t_refuse();
    host_u.send(16'h3011, 15);
    tick(8);
    host_u.send(16'h3011, 17);
    tick(8);
    chk(8'(vds), 8'h3f, "short or long frame");
  endtask

  task automatic t_direct();
    logic [1:0] ea, eb;
    for (int i = 0; i < 4; i++) begin
      pins = {i[1], i[0], i[1], i[0]};
      ea = (i == 3) ? 2'b10 : (i == 0) ? 2'b01 : 2'b00;
      eb = (i == 0) ? 2'b10 : (i == 3) ? 2'b01 : 2'b00;
      chk_gates({ea, eb}, 40);
    end
    pins = 4'b0110;
    chk_gates(4'h0, 40);
  endtask

  task automatic t_reg();
    logic [1:0] e;
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_CTRL, {2'b00, c[1], c[0], c[1], c[0]});
      e = (c == 2) ? 2'b10 : (c == 1) ? 2'b01 : 2'b00;
      chk_gates({e, e}, 40);
    end
  endtask

  task automatic t_combo();
    wr(ADDR_CTRL, 6'h06);
    pins = 4'b1110;
    chk_gates(4'b0010, 40);
    wr(ADDR_CTRL, 6'h0a);
    pins = 4'b1111;
    chk_gates(4'b1000, 40);
    wr(ADDR_CTRL, 6'h00);
    pins = 4'b0110;
    chk_gates(4'h0, 40);
  endtask

  task automatic t_dead();
    int cnt;
    pins = 4'b1110;
    chk_gates(4'b1000, 40);
    pins = 4'b0010;
    cnt = 0;
    for (int k = 0; k < 60 && a_lo !== 1'b1; k++) begin
      tick(1);
      if (a_up === 1'b0 && a_lo === 1'b0) cnt++;
    end
    chk(8'(cnt >= 6 && cnt <= 7), 8'h01, "dead gap");
    chk(8'(gates), 8'b0100, "low after gap");
    if (a_lo !== 1'b1) summarize();
  endtask

  task automatic t_fault();
    fault = 1'b1;
    tick(2);
    fault = 1'b0;
    tick(6);
    chk(8'(sdo_oe), 8'h00, "sdo idle");
    fork
      host_u.send(16'h0000, 16);
      begin
        tick(8);
        chk(8'({sdo_oe, sdo}), 8'h03, "sdo fault");
      end
    join
    tick(6);
    chk(8'(sdo_oe), 8'h00, "sdo float");
    chk(8'(fflag), 8'h01, "fault set");
    clr_n = 1'b0;
    tick(5);
    clr_n = 1'b1;
    tick(10);
    chk(8'({slp, fflag}), 8'h00, "fault cleared");
  endtask

  task automatic t_sleep();
    pins = 4'b1110;
    chk_gates(4'b1000, 40);
    clr_n = 1'b0;
    tick(320);
    chk(8'(slp), 8'h01, "sleep");
    chk(8'(gates), 8'h00, "sleep gates");
    clr_n = 1'b1;
    chk_gates(4'b1000, 40);
    chk(8'(slp), 8'h00, "wake");
  endtask

  task automatic t_enable();
    en = 1'b0;
    chk_gates(4'h0, 3);
    en = 1'b1;
    chk_gates(4'b1000, 40);
    mon = 1'b1;
    en = 1'b0;
    tick(400);
    chk(8'(gates), 8'b1000, "monitor hold");
    chk_gates(4'h0, 150);
    en = 1'b1;
    mon = 1'b0;
  endtask

  initial begin
    tick(8);
    i_rst_n = 1'b1;
    tick(6);
    t_settings();
    t_refuse();
    t_direct();
    t_reg();
    t_combo();
    t_dead();
    t_fault();
    t_sleep();
    t_enable();
    summarize();
  end
endmodule // tb_top

`default_nettype wire
